/* nvmg_pkg.sv */
// package: register map, field layout, reset values and timing for the eeprom write guard
package nvmg_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_UNLOCK = 8'h04;
	localparam logic [7:0] OFF_ADDR_LO = 8'h08;
	localparam logic [7:0] OFF_ADDR_HI = 8'h0C;
	localparam logic [7:0] OFF_DATA_LO = 8'h10;
	localparam logic [7:0] OFF_DATA_HI = 8'h14;
	localparam logic [7:0] OFF_INT_EN = 8'h18;
	localparam logic [7:0] OFF_INT_FLAG = 8'h1C;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	// control register fields
	localparam int CTRL_PSS = 7;
	localparam int CTRL_ABORT = 3;
	localparam int CTRL_PERMIT = 2;
	localparam int CTRL_WGO = 1;
	localparam int CTRL_RGO = 0;
	// interrupt enable / flag field
	localparam int INT_DONE = 4;
	// status register fields
	localparam int STAT_PWRT = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_ARMED = 2;
	// implemented widths
	localparam int ADDR_HI_W = 5;
	localparam int DATA_HI_W = 6;
	localparam int ARRAY_DEPTH = 256;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [ADDR_HI_W-1:0] RST_ADDR_HI = 5'h00;
	localparam logic [DATA_HI_W-1:0] RST_DATA_HI = 6'h00;
	// unlock key bytes
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	// timing
	localparam int CLK_MHZ = 125;
	localparam int PWRT_MS = 64;
	localparam int PWRT_CYCLES = PWRT_MS * CLK_MHZ * 1000;
	localparam int WRITE_NS = 2000;
	localparam int WRITE_CYCLES = (WRITE_NS * CLK_MHZ) / 1000;
	localparam logic [7:0] WRITE_LAST = 8'(WRITE_CYCLES - 1);
	// main sequencer states
	typedef enum logic [0:0] {ST_IDLE, ST_WRITE} nvmg_state_t;
endpackage

/* nvmg_pwrt.sv */
// power-up timer: holds busy high for a fixed count after reset release
module nvmg_pwrt import nvmg_pkg::*; #(
	parameter int unsigned CYCLES = PWRT_CYCLES
) (
	input wire logic hclk, // core clock
	input wire logic hresetn, // power-on / brown-out reset, active low
	input wire logic ce, // clock enable
	output logic busy_q // timer still running
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);
	logic [CW-1:0] cnt_q; // elapsed cycles
	wire done = (cnt_q == LAST); // interval over

	// count once after reset, then stop for good
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= '0;
			busy_q <= 1'b1;
		end else if (ce) begin
			if (!done) cnt_q <= cnt_q + CW'(1);
			busy_q <= ~done;
		end
	end
endmodule // nvmg_pwrt

/* nvmg_unlock.sv */
// unlock sequencer: tracks the two key writes that must precede a write start
module nvmg_unlock import nvmg_pkg::*; (
	input wire logic hclk, // core clock
	input wire logic hresetn, // reset, active low
	input wire logic ce, // clock enable
	input wire logic clr, // warm reset, drops any progress
	input wire logic wr_stb, // any register write this cycle
	input wire logic to_unlock, // that write targets the unlock port
	input wire logic [7:0] wdata, // byte written
	output logic armed_q // both keys seen, nothing else since
);
	typedef enum logic [1:0] {U_IDLE, U_GOT_FIRST, U_ARMED} nvmg_ustate_t;
	nvmg_ustate_t st_q, st_d;

	// any foreign write breaks the sequence, so it must be back to back
	always_comb begin
		st_d = st_q;
		if (clr) begin
			st_d = U_IDLE;
		end else if (wr_stb) begin
			case (st_q)
				U_IDLE: st_d = (to_unlock && wdata == KEY_FIRST) ? U_GOT_FIRST : U_IDLE;
				U_GOT_FIRST: begin
					if (to_unlock && wdata == KEY_SECOND) st_d = U_ARMED;
					else if (to_unlock && wdata == KEY_FIRST) st_d = U_GOT_FIRST;
					else st_d = U_IDLE;
				end
				U_ARMED: st_d = (to_unlock && wdata == KEY_FIRST) ? U_GOT_FIRST : U_IDLE;
				default: st_d = U_IDLE;
			endcase
		end
	end

	// state and registered armed output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= U_IDLE;
			armed_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			armed_q <= (st_d == U_ARMED);
		end
	end
endmodule // nvmg_unlock

/* nvmg_top.sv */
// data eeprom access and spurious-write guard behind an ahb-lite slave
module nvmg_top import nvmg_pkg::*; #(
	parameter int unsigned PWRT_LEN = PWRT_CYCLES // power-up interval in cycles
) (
	input wire logic hclk, // core clock, 125 MHz
	input wire logic hresetn, // power-on / brown-out reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic warm_rst, // other reset sources, synchronous, high
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size, word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready in
	output logic hreadyout_q, // slave ready
	output logic hresp_q, // response, always okay
	output logic [31:0] hrdata_q, // read data
	output logic irq_q, // level interrupt
	input wire logic data_protect_fuse, // zero means data protected
	input wire logic ext_req, // external programmer access pulse
	input wire logic ext_we, // external access is a write
	input wire logic [7:0] ext_addr, // external byte address
	input wire logic [7:0] ext_wdata, // external write byte
	output logic ext_ack_q, // external access answered
	output logic ext_denied_q, // external access refused
	output logic [7:0] ext_rdata_q // external read byte
);
	// register map, one byte per aligned word, upper bits read zero:
	//   0x00 control: program space select, abort flag, permit, write go, read go
	//   0x04 unlock port, write only, reads zero
	//   0x08 address low, selects the array byte
	//   0x0C address high, stored only, the array is 256 bytes deep
	//   0x10 data low, write source and read result
	//   0x14 data high, cleared by each array read
	//   0x18 interrupt enable, done enable at bit 4
	//   0x1C interrupt flag, done flag at bit 4, write one to clear
	//   0x20 status: armed, write busy, power-up timer running
	// every reset source clears the data path registers; only the
	// power-on reset also restarts the power-up timer

	// bus capture
	logic wr_pend_q; // write data phase in progress
	logic rd_pend_q; // read data phase in progress
	logic [7:0] baddr_q; // captured byte offset

	// visible registers
	logic pss_q; // program space select
	logic abort_q; // write abort flag
	logic permit_q; // write permit
	logic wgo_q; // write go, high while writing
	logic rgo_q; // read go, one cycle
	logic [7:0] addr_lo_q; // address low byte
	logic [ADDR_HI_W-1:0] addr_hi_q; // address high bits
	logic [7:0] data_lo_q; // data low byte
	logic [DATA_HI_W-1:0] data_hi_q; // data high bits
	logic done_ie_q; // done interrupt enable
	logic done_flag_q; // done sticky flag

	// write engine
	nvmg_state_t st_q; // sequencer state
	logic [7:0] wcnt_q; // write time counter
	logic [7:0] waddr_q; // latched write address
	logic [7:0] wdat_q; // latched write byte

	// the storage itself, one byte per address
	// no reset on the array; its contents survive every reset source
	logic [7:0] mem [ARRAY_DEPTH];

	// helper wires
	wire pwrt_busy; // power-up timer running
	wire armed; // unlock sequence complete

	// offset compare, used for every register
	// only the low address byte is decoded; the rest of haddr aliases
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// address phase acceptance
	// hsize is not checked: every register is one word, only bits 7:0 count
	wire take = hsel & htrans[1] & hready;
	wire take_wr = take & hwrite;
	wire take_rd = take & ~hwrite;

	// write data phase decode
	// runs in the data phase, from the offset held in baddr_q
	wire [7:0] wd = hwdata[7:0];
	wire w_ctrl = wr_pend_q & hit(baddr_q, OFF_CTRL);
	wire w_unlock = wr_pend_q & hit(baddr_q, OFF_UNLOCK);
	wire w_alo = wr_pend_q & hit(baddr_q, OFF_ADDR_LO);
	wire w_ahi = wr_pend_q & hit(baddr_q, OFF_ADDR_HI);
	wire w_dlo = wr_pend_q & hit(baddr_q, OFF_DATA_LO);
	wire w_dhi = wr_pend_q & hit(baddr_q, OFF_DATA_HI);
	wire w_ien = wr_pend_q & hit(baddr_q, OFF_INT_EN);
	wire w_iflag = wr_pend_q & hit(baddr_q, OFF_INT_FLAG);

	// a write start needs every guard at once; any one missing drops the
	// request silently, which keeps a runaway program away from the array
	// but means software must read back the go bit to know whether its
	// write was taken
	// start conditions
	wire idle = (st_q == ST_IDLE);
	// permit must already be set; fresh unlock; timer done; data space only
	wire start_wr = w_ctrl & wd[CTRL_WGO] & permit_q & armed & ~pwrt_busy
		& ~wd[CTRL_PSS] & idle & ~warm_rst;
	wire start_rd = w_ctrl & wd[CTRL_RGO] & ~wd[CTRL_PSS] & idle & ~warm_rst;
	wire wr_end = (st_q == ST_WRITE) & (wcnt_q == WRITE_LAST) & ~warm_rst;
	wire wr_abort = (st_q == ST_WRITE) & warm_rst;

	// external programmer path, only when the fuse leaves data open
	wire ext_open = data_protect_fuse;
	wire ext_wr = ext_req & ext_we & ext_open & idle;

	// combined array read port
	// follows address low directly; a read go samples it one cycle later
	wire [7:0] mem_rd = mem[addr_lo_q];

	// control readback, unimplemented bits read zero
	wire [7:0] ctrl_rd = {pss_q, 3'b000, abort_q, permit_q, wgo_q, rgo_q};
	wire [7:0] stat_rd = {5'b00000, armed, ~idle, pwrt_busy};

	// register read mux
	// decoded from the offset captured at the address edge, so the
	// answer is ready for the cycle after the wait state
	wire [7:0] rd_mux =
		hit(baddr_q, OFF_CTRL) ? ctrl_rd :
		hit(baddr_q, OFF_ADDR_LO) ? addr_lo_q :
		hit(baddr_q, OFF_ADDR_HI) ? {3'b000, addr_hi_q} :
		hit(baddr_q, OFF_DATA_LO) ? data_lo_q :
		hit(baddr_q, OFF_DATA_HI) ? {2'b00, data_hi_q} :
		hit(baddr_q, OFF_INT_EN) ? 8'(done_ie_q) << INT_DONE :
		hit(baddr_q, OFF_INT_FLAG) ? 8'(done_flag_q) << INT_DONE :
		hit(baddr_q, OFF_STATUS) ? stat_rd :
		RST_BYTE; // unlock port and unmapped read zero

	// sticky done flag: set beats the write-one clear
	// a clear that lands on the finishing edge loses, so no done is missed
	wire flag_clr = w_iflag & wd[INT_DONE];
	wire flag_d = wr_end | (done_flag_q & ~flag_clr);

	// power-up timer
	// only the power-on reset restarts it; warm resets leave it alone
	// the interval is a parameter so simulation can shorten it
	nvmg_pwrt #(
		.CYCLES(PWRT_LEN)
	) u_pwrt (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.busy_q(pwrt_busy)
	);

	// unlock key tracker
	// every write data phase counts, mapped or not, so any stray store
	// between the keys and the go write breaks the sequence
	nvmg_unlock u_unlock (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.clr(warm_rst),
		.wr_stb(wr_pend_q),
		.to_unlock(w_unlock),
		.wdata(wd),
		.armed_q(armed)
	);

	// bus phases; reads take one wait state so a write just before is seen
	// writes complete in their single data phase; the response is always
	// okay, unmapped offsets read zero and writes to them vanish
	// ce low freezes this too; the master sees a longer wait only if hreadyout_q was low, otherwise its transfers are not captured
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			baddr_q <= RST_BYTE;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			hrdata_q <= '0;
		end else if (ce) begin
			wr_pend_q <= take_wr;
			rd_pend_q <= take_rd;
			if (take) baddr_q <= haddr[7:0];
			if (take_rd) begin
				hreadyout_q <= 1'b0; // hold master one cycle
			end else if (rd_pend_q) begin
				hreadyout_q <= 1'b1;
				hrdata_q <= {24'h000000, rd_mux};
			end
		end
	end

	// control register bits
	// permit must already stand when the go write arrives: setting both in
	// one store starts nothing, which costs software one extra store but
	// keeps a single stray write from ever reaching the array
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pss_q <= 1'b0;
			abort_q <= 1'b0;
			permit_q <= 1'b0;
			wgo_q <= 1'b0;
			rgo_q <= 1'b0;
		end else if (ce) begin
			if (warm_rst) begin
				// other resets keep the abort flag, mark a cut write
				pss_q <= 1'b0;
				permit_q <= 1'b0;
				wgo_q <= 1'b0;
				rgo_q <= 1'b0;
				if (wr_abort) abort_q <= 1'b1;
			end else begin
				if (w_ctrl) begin
					pss_q <= wd[CTRL_PSS];
					permit_q <= wd[CTRL_PERMIT];
					abort_q <= abort_q & wd[CTRL_ABORT]; // software may only clear
				end
				// go bits are set-only from software
				if (start_wr) wgo_q <= 1'b1;
				else if (wr_end) wgo_q <= 1'b0;
				rgo_q <= start_rd;
			end
		end
	end

	// address and data registers, cleared by every reset
	// address high is stored for software only; the array is 256 bytes
	// deep and address low alone selects the byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_lo_q <= RST_BYTE;
			addr_hi_q <= RST_ADDR_HI;
			data_lo_q <= RST_BYTE;
			data_hi_q <= RST_DATA_HI;
		end else if (ce) begin
			if (warm_rst) begin
				addr_lo_q <= RST_BYTE;
				addr_hi_q <= RST_ADDR_HI;
				data_lo_q <= RST_BYTE;
				data_hi_q <= RST_DATA_HI;
			end else begin
				if (w_alo) addr_lo_q <= wd;
				if (w_ahi) addr_hi_q <= wd[ADDR_HI_W-1:0];
				if (w_dhi) data_hi_q <= wd[DATA_HI_W-1:0];
				// read result lands one cycle after read go
				if (rgo_q) begin
					data_lo_q <= mem_rd;
					data_hi_q <= RST_DATA_HI;
				end else if (w_dlo) begin
					data_lo_q <= wd;
				end
			end
		end
	end

	// write sequencer: address and byte latched at start
	// the latched copies let software reload address and data while a write
	// runs without changing the byte being written; a warm reset cuts the
	// write short and the control logic marks it in the abort flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= ST_IDLE;
			wcnt_q <= RST_BYTE;
			waddr_q <= RST_BYTE;
			wdat_q <= RST_BYTE;
		end else if (ce) begin
			case (st_q)
				ST_IDLE: begin
					if (start_wr) begin
						st_q <= ST_WRITE;
						wcnt_q <= RST_BYTE;
						waddr_q <= addr_lo_q;
						wdat_q <= data_lo_q;
					end
				end
				ST_WRITE: begin
					if (warm_rst || wr_end) st_q <= ST_IDLE;
					else wcnt_q <= wcnt_q + 8'h01;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// array write port; cpu write completion has priority
	// external writes need the engine idle, so the two sources never meet
	// in practice; the priority only states the intent
	always_ff @(posedge hclk) begin
		if (ce) begin
			if (wr_end) mem[waddr_q] <= wdat_q;
			else if (ext_wr) mem[ext_addr] <= ext_wdata;
		end
	end

	// interrupt enable and sticky flag
	// the line follows an enable write on the same edge, so masking takes
	// effect at once and unmasking a pending flag raises it at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_ie_q <= 1'b0;
			done_flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (ce) begin
			if (warm_rst) begin
				done_ie_q <= 1'b0;
				done_flag_q <= 1'b0;
				irq_q <= 1'b0;
			end else begin
				if (w_ien) done_ie_q <= wd[INT_DONE];
				done_flag_q <= flag_d;
				irq_q <= flag_d & (w_ien ? wd[INT_DONE] : done_ie_q);
			end
		end
	end

	// external access answers one cycle later; denied reads give zero
	// the fuse is looked at on the request edge only; a change in the
	// middle of a burst applies from the next request on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_ack_q <= 1'b0;
			ext_denied_q <= 1'b0;
			ext_rdata_q <= RST_BYTE;
		end else if (ce) begin
			ext_ack_q <= ext_req;
			ext_denied_q <= ext_req & ~ext_open;
			// a refused access of either kind blanks the read byte, so a
			// probe never sees what an earlier allowed read left behind
			if (ext_req && !ext_open) ext_rdata_q <= RST_BYTE;
			else if (ext_req && !ext_we) ext_rdata_q <= mem[ext_addr];
		end
	end
endmodule // nvmg_top

/* nvmg_top_properties.sv */
// checker: bus timing and external-port answers of the eeprom guard
module nvmg_top_properties import nvmg_pkg::*; #(
	parameter int unsigned PWRT_LEN = PWRT_CYCLES // power-up interval
) (
	input wire logic hclk, // core clock
	input wire logic hresetn, // reset, active low
	input wire logic ce, // clock enable
	input wire logic hsel, // slave select
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write flag
	input wire logic hready, // bus ready
	input wire logic hreadyout_q, // slave ready
	input wire logic hresp_q, // response
	input wire logic [31:0] hrdata_q, // read data
	input wire logic irq_q, // interrupt
	input wire logic data_protect_fuse, // protect fuse
	input wire logic ext_req, // external request
	input wire logic ext_ack_q, // external ack
	input wire logic ext_denied_q, // external refusal
	input wire logic [7:0] ext_rdata_q // external read byte
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// accepted transfers, split by direction
	wire logic acc_rd = hsel && htrans[1] && hready && ce && !hwrite;
	wire logic acc_wr = hsel && htrans[1] && hready && ce && hwrite;
	a_read_wait: assert property (acc_rd |=> !hreadyout_q ##1 hreadyout_q)
		else $error("read wait state wrong");
	a_write_nowait: assert property (acc_wr |=> hreadyout_q)
		else $error("write stalled");
	a_resp_okay: assert property (hresp_q == 1'b0)
		else $error("response not okay");
	a_upper_zero: assert property (hrdata_q[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_ext_ack: assert property (ext_req && ce |=> ext_ack_q)
		else $error("external ack missing");
	a_ext_deny: assert property (ext_req && ce |=> ext_denied_q != $past(data_protect_fuse))
		else $error("external refusal wrong");
	a_ack_cause: assert property (ext_ack_q |-> $past(ext_req))
		else $error("ack without request");
	a_denied_blank: assert property (ext_denied_q |-> ext_rdata_q == 8'h00)
		else $error("refused access leaked data");
	c_read: cover property (acc_rd ##2 hreadyout_q);
	c_deny: cover property (ext_denied_q);
	c_irq: cover property ($rose(irq_q));
endmodule // nvmg_top_properties

bind nvmg_top nvmg_top_properties #(.PWRT_LEN(PWRT_LEN)) nvmg_top_properties_i (.hclk, .hresetn,
	.ce, .hsel, .htrans, .hwrite, .hready, .hreadyout_q, .hresp_q, .hrdata_q, .irq_q,
	.data_protect_fuse, .ext_req, .ext_ack_q, .ext_denied_q, .ext_rdata_q);

/* nvmg_top_tb.sv */
// testbench: register map, write guard, interrupt, external port
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module nvmg_top_tb import nvmg_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned PLEN = 100; // short power-up interval
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} nvmg_row_t;
	logic hclk = 1'b0, hresetn = 1'b0, warm_rst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic fuse = 1'b1, ext_req = 1'b0, ext_we = 1'b0, ce = 1'b1;
	logic [7:0] ext_addr = 8'h00, ext_wdata = 8'h00, ext_rdata_q;
	logic hreadyout_q, hresp_q, irq_q, ext_ack_q, ext_denied_q;
	logic [31:0] hrdata_q;
	int err_total = 0, num_checks = 0, cyc = 0;
	// ordinary cases: offset, written byte, byte read back
	nvmg_row_t rows [7] = '{'{OFF_ADDR_LO, 8'hA5, 8'hA5}, '{OFF_ADDR_HI, 8'hFF, 8'h1F},
		'{OFF_DATA_LO, 8'h3C, 8'h3C}, '{OFF_DATA_HI, 8'hFF, 8'h3F}, '{OFF_INT_EN, 8'h10, 8'h10},
		'{OFF_UNLOCK, 8'h55, 8'h00}, '{8'h24, 8'hFF, 8'h00}};
	always #4 hclk = ~hclk;
	nvmg_top #(.PWRT_LEN(PLEN)) nvmg_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.warm_rst(warm_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'b010), .hwdata(hwdata), .hready(hreadyout_q), .hreadyout_q(hreadyout_q),
		.hresp_q(hresp_q), .hrdata_q(hrdata_q), .irq_q(irq_q), .data_protect_fuse(fuse),
		.ext_req(ext_req), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
		.ext_ack_q(ext_ack_q), .ext_denied_q(ext_denied_q), .ext_rdata_q(ext_rdata_q));
	// verdict and stop, also used by the watchdog
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one ahb-lite single transfer; read byte returned in q
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout_q !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		do @(posedge hclk); while (hreadyout_q !== 1'b1);
		q = hrdata_q[7:0];
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, a, d, q);
	endtask
	// read and compare
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		xfer(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask
	// key pair then write go, permit kept set
	task automatic go();
		wr(OFF_UNLOCK, KEY_FIRST);
		wr(OFF_UNLOCK, KEY_SECOND);
		wr(OFF_CTRL, 8'h06);
	endtask
	// external programmer access; ack seen one edge later
	task automatic ext(input logic w, input logic [7:0] d, input logic dn, input logic [7:0] e);
		ext_req <= 1'b1;
		ext_we <= w;
		ext_addr <= 8'h09;
		ext_wdata <= d;
		@(posedge hclk);
		ext_req <= 1'b0;
		@(posedge hclk);
		`CHK(({ext_ack_q, ext_denied_q}), ({1'b1, dn}))
		if (!w) begin
			`CHK(ext_rdata_q, e)
		end
	endtask
	// watchdog against a hung handshake
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rc(OFF_STATUS, 8'h01);
		rc(OFF_CTRL, 8'h00);
		wr(OFF_CTRL, 8'h04);
		go();
		rc(OFF_CTRL, 8'h04);
		repeat (PLEN) @(posedge hclk);
		rc(OFF_STATUS, 8'h00);
		$display("power-up guard done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e);
		end
		$display("register rows done");
		wr(OFF_CTRL, 8'h06);
		rc(OFF_CTRL, 8'h04);
		wr(OFF_UNLOCK, KEY_FIRST);
		wr(OFF_ADDR_LO, 8'h07);
		wr(OFF_UNLOCK, KEY_SECOND);
		wr(OFF_CTRL, 8'h06);
		rc(OFF_CTRL, 8'h04);
		wr(OFF_UNLOCK, KEY_FIRST);
		wr(OFF_UNLOCK, KEY_SECOND);
		rc(OFF_STATUS, 8'h04);
		wr(OFF_CTRL, 8'h86);
		rc(OFF_CTRL, 8'h84);
		$display("refused starts done");
		wr(OFF_DATA_LO, 8'h5A);
		go();
		rc(OFF_CTRL, 8'h06);
		rc(OFF_STATUS, 8'h02);
		ce <= 1'b0;
		repeat (300) @(posedge hclk);
		ce <= 1'b1;
		rc(OFF_CTRL, 8'h06);
		`CHK(irq_q, 1'b0)
		for (int n = 0; n < 400 && irq_q !== 1'b1; n++) @(posedge hclk);
		`CHK(irq_q, 1'b1)
		rc(OFF_INT_FLAG, 8'h10);
		rc(OFF_CTRL, 8'h04);
		wr(OFF_INT_EN, 8'h00);
		repeat (2) @(posedge hclk);
		`CHK(irq_q, 1'b0)
		wr(OFF_INT_EN, 8'h10);
		wr(OFF_INT_FLAG, 8'h10);
		rc(OFF_INT_FLAG, 8'h00);
		`CHK(irq_q, 1'b0)
		wr(OFF_DATA_LO, 8'h00);
		wr(OFF_CTRL, 8'h05);
		repeat (3) @(posedge hclk);
		rc(OFF_DATA_LO, 8'h5A);
		$display("write and interrupt done");
		ext(1'b1, 8'h77, 1'b0, 8'h00);
		ext(1'b0, 8'h00, 1'b0, 8'h77);
		fuse <= 1'b0;
		ext(1'b0, 8'h00, 1'b1, 8'h00);
		ext(1'b1, 8'h11, 1'b1, 8'h00);
		fuse <= 1'b1;
		ext(1'b0, 8'h00, 1'b0, 8'h77);
		wr(OFF_ADDR_LO, 8'h09);
		wr(OFF_CTRL, 8'h05);
		repeat (3) @(posedge hclk);
		rc(OFF_DATA_LO, 8'h77);
		$display("external port done");
		wr(OFF_ADDR_HI, 8'h1F);
		go();
		repeat (10) @(posedge hclk);
		warm_rst <= 1'b1;
		@(posedge hclk);
		warm_rst <= 1'b0;
		rc(OFF_CTRL, 8'h08);
		rc(OFF_ADDR_HI, 8'h00);
		rc(OFF_DATA_HI, 8'h00);
		wr(OFF_CTRL, 8'h08);
		rc(OFF_CTRL, 8'h08);
		wr(OFF_CTRL, 8'h00);
		rc(OFF_CTRL, 8'h00);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rc(OFF_CTRL, 8'h00);
		rc(OFF_STATUS, 8'h01);
		$display("resets done");
		end_of_test();
	end
endmodule // nvmg_top_tb
